/* File: rtl/cis_pkg.sv */
// Package for the idle/ready command state handler: offsets, fields, states, timing
`default_nettype none
package cis_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] STS_OFFSET  = 8'h00;
  localparam logic [7:0] FIFO_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_OFFSET = 8'h08;
  // Status field positions
  localparam int STS_EXPECT_BIT   = 3;
  localparam int STS_AVAIL_BIT    = 4;
  localparam int STS_RETRY_BIT    = 1;
  localparam int STS_GO_BIT       = 5;
  localparam int STS_CMDRDY_BIT   = 6;
  // Control register field positions
  localparam int CTRL_AUTO_EN_BIT = 0;
  localparam int CTRL_SET_IDLE_BIT = 1;
  // Reset value and fixed read values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [7:0]  FIFO_EMPTY_BYTE = 8'hff;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Idle timeout, in microseconds, and the clock rate it counts at
  localparam int IDLE_TIMEOUT_US = 750;
  localparam int CLK_MHZ         = 100;
  localparam int IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_US * CLK_MHZ;
  // Device command states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_READY = 5'b00010,
    ST_RECV  = 5'b00100,
    ST_EXEC  = 5'b01000,
    ST_DONE  = 5'b10000
  } cis_state_t;
  // Register bus request carried as one bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cis_req_t;
  // Decoded status-write control bits
  typedef struct packed {
    logic cmd_ready;
    logic go;
    logic retry;
  } cis_ctl_t;
endpackage
`default_nettype wire

/* File: rtl/cis_cmd_state.sv */
// Idle and Ready handling of the status-driven command state machine
`default_nettype none
module cis_cmd_state
#(
  parameter int IDLE_TIMEOUT = cis_pkg::IDLE_TIMEOUT_CYCLES,
  parameter int CNT_W        = 24
)
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire cis_pkg::cis_req_t req,
  output var  logic [31:0]       rdata,
  output var  logic [4:0]        state_out,
  output var  logic              fifo_wr_drop,
  output var  logic              idle_expired
);

  // Host request classes seen by the Idle/Ready decode, one-hot
  // Only one class holds in a cycle, so the state decode needs no priority
  typedef enum logic [6:0] {
    WK_NONE   = 7'b0000001,
    WK_RETRY  = 7'b0000010,
    WK_GO     = 7'b0000100,
    WK_CMDRDY = 7'b0001000,
    WK_NOOP   = 7'b0010000,
    WK_FIFO   = 7'b0100000,
    WK_CTRL   = 7'b1000000
  } cis_wkind_t;

  // State, idle timer and decode signals
  cis_pkg::cis_state_t state_r;
  cis_pkg::cis_state_t state_nxt;
  cis_wkind_t          wkind;
  logic [CNT_W-1:0]    idle_cnt_r;
  logic [CNT_W-1:0]    idle_limit;
  logic                auto_en_r;
  logic                expect_r;
  logic                sts_wr;
  logic                sts_rd;
  logic                fifo_wr;
  logic                fifo_rd;
  logic                ctrl_wr;
  logic                ctrl_rd;
  logic                force_idle;
  logic                timed_out;
  logic                auto_ok;
  logic                in_idle;
  logic                in_ready;
  logic [31:0]         sts_word;
  logic [31:0]         rd_mux;
  cis_pkg::cis_ctl_t   ctl;

  // Number of control bits set in a status write
  function automatic logic [1:0] ctl_count(input cis_pkg::cis_ctl_t c);
    ctl_count = {1'b0, c.cmd_ready} + {1'b0, c.go} + {1'b0, c.retry};
  endfunction

  // Offset match, shared by every register decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] offs);
    addr_hit = (a == offs);
  endfunction

  // Status word from the reported bits; every other position reads 0
  function automatic logic [31:0] sts_pack
  (
    input logic rdy,
    input logic avail,
    input logic expct
  );
    sts_pack = '0;
    sts_pack[cis_pkg::STS_CMDRDY_BIT] = rdy;
    sts_pack[cis_pkg::STS_AVAIL_BIT]  = avail;
    sts_pack[cis_pkg::STS_EXPECT_BIT] = expct;
  endfunction

  // Address decode; a strobe at an unmapped offset changes nothing
  assign sts_wr     = req.wr && addr_hit(req.addr, cis_pkg::STS_OFFSET);
  assign sts_rd     = req.rd && addr_hit(req.addr, cis_pkg::STS_OFFSET);
  assign fifo_wr    = req.wr && addr_hit(req.addr, cis_pkg::FIFO_OFFSET);
  assign fifo_rd    = req.rd && addr_hit(req.addr, cis_pkg::FIFO_OFFSET);
  assign ctrl_wr    = req.wr && addr_hit(req.addr, cis_pkg::CTRL_OFFSET);
  assign ctrl_rd    = req.rd && addr_hit(req.addr, cis_pkg::CTRL_OFFSET);
  assign force_idle = ctrl_wr && req.wdata[cis_pkg::CTRL_SET_IDLE_BIT];

  // Control bits of a status write, gathered in one assignment
  assign ctl = '{
    cmd_ready: req.wdata[cis_pkg::STS_CMDRDY_BIT],
    go:        req.wdata[cis_pkg::STS_GO_BIT],
    retry:     req.wdata[cis_pkg::STS_RETRY_BIT]
  };

  // State flags used by the read path and the outputs
  assign in_idle  = (state_r == cis_pkg::ST_IDLE);
  assign in_ready = (state_r == cis_pkg::ST_READY);

  // Timeout compare; the limit is cut to the counter width on purpose
  // The counter saturates at the limit, so the compare never wraps
  assign idle_limit = CNT_W'(IDLE_TIMEOUT);
  assign timed_out  = (idle_cnt_r >= idle_limit);
  // Autonomous Ready entry is allowed only while under the limit
  assign auto_ok    = auto_en_r && !timed_out;

  // Classify the request; status writes other than a single bit are no-ops
  always_comb
  begin
    wkind = WK_NONE;
    if (sts_wr)
    begin
      case (ctl_count(ctl))
        2'd1:
        begin
          if (ctl.cmd_ready)
            wkind = WK_CMDRDY;
          else if (ctl.go)
            wkind = WK_GO;
          else
            wkind = WK_RETRY;
        end
        2'd0:
        begin
          // A status write with no control bit set is taken and ignored
          wkind = WK_NOOP;
        end
        default:
        begin
          wkind = WK_NOOP;
        end
      endcase
    end
    else if (fifo_wr)
      wkind = WK_FIFO;
    else if (ctrl_wr)
      wkind = WK_CTRL;
  end

  // Next state: only Idle and Ready are handled here; others fall back to Idle
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      cis_pkg::ST_IDLE:
      begin
        case (wkind)
          WK_CMDRDY:
          begin
            state_nxt = cis_pkg::ST_READY;
          end
          WK_RETRY:
          begin
            state_nxt = cis_pkg::ST_IDLE;
          end
          WK_GO:
          begin
            state_nxt = cis_pkg::ST_IDLE;
          end
          WK_NOOP:
          begin
            state_nxt = cis_pkg::ST_IDLE;
          end
          WK_FIFO:
          begin
            // Data is dropped, so a command in flight must be sent again
            state_nxt = cis_pkg::ST_IDLE;
          end
          default:
          begin
            // Quiet cycle or control write: autonomous exit while allowed
            if (auto_ok)
              state_nxt = cis_pkg::ST_READY;
            else
              state_nxt = cis_pkg::ST_IDLE;
          end
        endcase
      end
      cis_pkg::ST_READY:
      begin
        case (wkind)
          WK_RETRY:
          begin
            state_nxt = cis_pkg::ST_READY;
          end
          WK_GO:
          begin
            state_nxt = cis_pkg::ST_READY;
          end
          WK_CMDRDY:
          begin
            state_nxt = cis_pkg::ST_READY;
          end
          WK_NOOP:
          begin
            state_nxt = cis_pkg::ST_READY;
          end
          WK_CTRL:
          begin
            // Test hook: a forced idle also restarts the idle timer
            if (force_idle)
              state_nxt = cis_pkg::ST_IDLE;
            else
              state_nxt = cis_pkg::ST_READY;
          end
          default:
          begin
            state_nxt = cis_pkg::ST_READY;
          end
        endcase
      end
      default:
      begin
        state_nxt = cis_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_r <= cis_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Idle counter restarts whenever Idle is (re)entered, saturates at the timeout
  always_ff @(posedge core_clk)
  begin
    if (rst || state_r != cis_pkg::ST_IDLE)
      idle_cnt_r <= '0;
    else if (!timed_out)
      idle_cnt_r <= idle_cnt_r + CNT_W'(1);
  end

  // Control register: autonomous Ready enable
  always_ff @(posedge core_clk)
  begin
    if (rst)
      auto_en_r <= cis_pkg::CTRL_RESET[cis_pkg::CTRL_AUTO_EN_BIT];
    else if (ctrl_wr)
      auto_en_r <= req.wdata[cis_pkg::CTRL_AUTO_EN_BIT];
  end

  // Expect is free in Ready; held at 0 since host must cope either way
  always_ff @(posedge core_clk)
  begin
    if (rst)
      expect_r <= 1'b0;
    else
      expect_r <= 1'b0;
  end

  // Status word as the host sees it; no response ever exists here
  assign sts_word = sts_pack(in_ready, 1'b0, expect_r);

  // Read multiplexer; unmapped offsets read the fixed unmapped word
  always_comb
  begin
    rd_mux = cis_pkg::UNMAPPED_READ;
    if (sts_rd)
      rd_mux = sts_word;
    else if (fifo_rd)
      rd_mux[7:0] = cis_pkg::FIFO_EMPTY_BYTE;
    else if (ctrl_rd)
      rd_mux[cis_pkg::CTRL_AUTO_EN_BIT] = auto_en_r;
  end

  // Read data register: the word stands only for the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata <= '0;
    else if (req.rd)
      rdata <= rd_mux;
    else
      rdata <= '0;
  end

  // State mirror for the host side; it tracks the state register exactly
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_out <= cis_pkg::ST_IDLE;
    else
      state_out <= state_nxt;
  end

  // One pulse for every FIFO write thrown away in Idle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fifo_wr_drop <= 1'b0;
    else
      fifo_wr_drop <= (wkind == WK_FIFO) && in_idle;
  end

  // Level: Idle has outlasted the timeout, so only a host command leaves it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      idle_expired <= 1'b0;
    else
      idle_expired <= in_idle && timed_out;
  end

endmodule
`default_nettype wire

/* File: dv/cis_cmd_state_props.sv */
// Checker for idle and ready status handling
`default_nettype none
module cis_cmd_state_props
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire cis_pkg::cis_req_t req,
  input wire logic [31:0]       rdata,
  input wire logic [4:0]        state_out,
  input wire logic              fifo_wr_drop,
  input wire logic              idle_expired
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Decoded views; control bits are cmd_ready, go, retry
  wire logic       sw  = req.wr && req.addr == cis_pkg::STS_OFFSET;
  wire logic       sr  = req.rd && req.addr == cis_pkg::STS_OFFSET;
  wire logic       fa  = req.addr == cis_pkg::FIFO_OFFSET;
  wire logic [2:0] ctl = {req.wdata[6], req.wdata[5], req.wdata[1]};
  wire logic       idl = state_out == cis_pkg::ST_IDLE;
  wire logic       rdy = state_out == cis_pkg::ST_READY;
  // Idle past timeout: no autonomous exit can mask a fault
  sequence s_held; idl && idle_expired; endsequence
  a_held_idle: assert property (s_held ##0 !(sw && ctl == 3'b100) |=> idl)
    else $error("left idle");
  a_idle_ignore: assert property (s_held ##0 (sw && ctl != 3'b100) |=> idl)
    else $error("status write moved idle");
  a_cmdrdy_ready: assert property (idl && sw && ctl == 3'b100 |=> rdy)
    else $error("no ready");
  a_drop_idle: assert property (fifo_wr_drop == $past(idl && req.wr && fa))
    else $error("drop pulse wrong");
  a_fifo_ff: assert property (req.rd && fa |=> rdata[7:0] == cis_pkg::FIFO_EMPTY_BYTE)
    else $error("fifo read not ff");
  a_ready_holds: assert property (rdy && sw |=> rdy)
    else $error("left ready");
  a_ready_sts: assert property (rdy && sr |=> rdata[6] && !rdata[4])
    else $error("ready status wrong");
  a_idle_sts: assert property (s_held ##0 sr |=> !rdata[6] && !rdata[4])
    else $error("idle status wrong");
endmodule
bind cis_cmd_state cis_cmd_state_props i_props (.core_clk(core_clk), .rst(rst), .req(req),
  .rdata(rdata), .state_out(state_out), .fifo_wr_drop(fifo_wr_drop),
  .idle_expired(idle_expired));
`default_nettype wire

/* File: dv/cis_host_model.sv */
// Host software model: bus master for status and data FIFO
`default_nettype none
module cis_host_model
(
  input wire logic               core_clk,
  output var cis_pkg::cis_req_t  req,
  input wire logic [31:0]        rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_rd;
  // Expect may read either way, so software masks it
  logic [31:0] sts_seen;
  initial req = '0;
  // One-cycle write strobe launched at a rising edge; returns once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1 last_rd = rdata;
    sts_seen = last_rd & 32'hffff_fff7;
  endtask
endmodule
`default_nettype wire

/* File: dv/cis_cmd_state_tb.sv */
// Self-checking bench for idle and ready handling
`default_nettype none
`define H i_cis_host_model
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module cis_cmd_state_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 20;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  int                errors = 0;
  int                compares = 0;
  int                cyc = 0;
  cis_pkg::cis_req_t req;
  logic [31:0]       rdata;
  logic [4:0]        state_out;
  logic              fifo_wr_drop;
  logic              idle_expired;
  always #5 core_clk = ~core_clk;
  cis_cmd_state #(.IDLE_TIMEOUT(TO), .CNT_W(24)) i_cis_cmd_state (.core_clk(core_clk),
    .rst(rst), .req(req), .rdata(rdata), .state_out(state_out),
    .fifo_wr_drop(fifo_wr_drop), .idle_expired(idle_expired));
  cis_host_model i_cis_host_model (.core_clk(core_clk), .req(req), .rdata(rdata));
  // Status word from cmd_ready, go, retry
  function automatic logic [31:0] sts(input logic [2:0] c);
    return {25'h0, c[2:1], 3'h0, c[0], 1'b0};
  endfunction
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      end_sim();
    end
  end
  // Idle: drops, timeout, refusals, then host command
  task automatic t_idle();
    `H.wr(8'h08, 32'h2);
    `H.wr(8'h04, 32'ha5);
    `CHK(state_out, cis_pkg::ST_IDLE)
    `CHK(fifo_wr_drop, 1'b1)
    `H.rd(8'h04);
    `CHK(`H.last_rd[7:0], 8'hff)
    repeat (TO + 2) @(posedge core_clk);
    #1 `CHK(idle_expired, 1'b1)
    // Re-enable auto entry: timed out, so Idle must still hold below
    `H.wr(8'h08, 32'h1);
    for (int c = 1; c < 8; c++)
    begin
      if (c != 4) `H.wr(8'h00, sts(c[2:0]));
      `CHK(state_out, cis_pkg::ST_IDLE)
    end
    `H.rd(8'h00);
    `CHK(`H.sts_seen[6:4], 3'h0)
    `H.wr(8'h00, sts(3'b100));
    `CHK(state_out, cis_pkg::ST_READY)
    `H.rd(8'h00);
    `CHK({`H.sts_seen[6], `H.sts_seen[4]}, 2'b10)
    $display("idle test done");
  endtask
  // Ready ignores every status write with a control bit set
  task automatic t_ready();
    for (int c = 1; c < 8; c++)
    begin
      `H.wr(8'h00, sts(c[2:0]));
      `CHK(state_out, cis_pkg::ST_READY)
    end
    $display("ready test done");
  endtask
  // Idle entry with auto enabled goes straight back to ready
  task automatic t_auto();
    `H.wr(8'h08, 32'h3);
    @(posedge core_clk);
    #1 `CHK(state_out, cis_pkg::ST_READY)
    `CHK(idle_expired, 1'b0)
    $display("auto test done");
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_idle();
    t_ready();
    t_auto();
    end_sim();
  end
endmodule
`default_nettype wire
